// ---- mcs_pkg.sv ----
package mcs_pkg;

  // clock and time base
  localparam int unsigned CLK_HZ          = 125_000_000;
  localparam int unsigned TICK_PERIOD_S   = 1;
  localparam int unsigned TICK_CYCLES_DEF = CLK_HZ * TICK_PERIOD_S;
  localparam int unsigned TICK_CW         = 27;

  // seconds, all time values are 17 bits wide
  localparam int unsigned TW          = 17;
  localparam logic [16:0] MEAS_MIN    = 17'h0001e;
  localparam logic [16:0] MEAS_MAX    = 17'h0012c;
  localparam logic [16:0] MEAS_DEF    = 17'h0003c;
  localparam logic [16:0] PAUSE_MIN   = 17'h00001;
  localparam logic [16:0] PAUSE_MAX   = 17'h15180;
  localparam logic [16:0] PAUSE_DEF   = 17'h0000a;
  localparam logic [16:0] REG_TIME_S  = 17'h00002;
  localparam logic [16:0] AUTO_MIN_S  = 17'h0002d;
  localparam logic [16:0] AUTO_MAX_S  = 17'h0012c;
  localparam logic [16:0] SEC_PER_MIN = 17'h0003c;
  localparam logic [16:0] EDIT_MAX    = 17'h1869f;
  localparam logic [16:0] ENUM_LIMIT  = 17'h00004;

  // ordinal formatting
  localparam logic [4:0] ISO_LE6_LO = 5'h01;
  localparam logic [4:0] ISO_LE6_HI = 5'h06;

  // register map
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_MEAS   = 8'h04;
  localparam logic [7:0] ADDR_PAUSE  = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_TIME   = 8'h10;
  localparam logic [7:0] ADDR_LAST   = 8'h14;
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_STD_LSB  = 2;
  localparam int unsigned CTRL_RUN_BIT  = 4;
  localparam int unsigned ST_PHASE_LSB  = 0;
  localparam int unsigned ST_DASH_BIT   = 2;
  localparam int unsigned ST_MENU_LSB   = 4;
  localparam int unsigned ST_CUR_LSB    = 8;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [1:0] STD_RST  = 2'h0;

  typedef enum logic [1:0] {MODE_TIME, MODE_DIGIO, MODE_BUTTON, MODE_AUTO} mcs_mode_t;
  typedef enum logic [1:0] {STD_ISO, STD_SAE, STD_NAS, STD_GOST} mcs_std_t;
  typedef enum logic [1:0] {PH_IDLE, PH_REGULATE, PH_MEASURE, PH_PAUSE} mcs_phase_t;
  typedef enum logic [1:0] {MENU_TOP, MENU_LIST, MENU_EDIT} mcs_menu_t;
  typedef enum logic [1:0] {ITEM_MODE, ITEM_MEAS, ITEM_PAUSE, ITEM_STD} mcs_item_t;
  typedef enum logic [1:0] {SYM_RUN, SYM_RUN_FLASH, SYM_PAUSE} mcs_sym_t;

  typedef struct packed {
    logic [4:0] ch4;
    logic [4:0] ch6;
    logic [4:0] ch14;
    logic [4:0] ch21;
    logic [4:0] single;
  } mcs_ord_in_t;

  typedef struct packed {
    logic [4:0] num_a;
    logic [4:0] num_b;
    logic [4:0] num_c;
    logic [4:0] num_d;
    logic [2:0] le6;
    logic       small_d;
    logic [2:0] count;
  } mcs_ord_disp_t;

  typedef struct packed {
    logic        dashes;
    logic [10:0] minutes;
    logic [5:0]  seconds;
  } mcs_time_disp_t;

endpackage : mcs_pkg

// ---- mcs_sequencer.sv ----
//
// Contract
// - measuring time accepted only within 30..300 s, default 60 s
// - time mode alternates measurement and pause; pause 1 s .. one day
// - factory defaults 60 s measuring and 10 s pause
// - each measurement opens with a laser regulation phase, symbol flashing
// - time mode measurement shows remaining time as minutes:seconds
// - time mode pause shows time remaining until next measurement
// - pause shortened below elapsed shows dashes until original end
// - digital mode measures while start/stop input high or open
// - digital mode pauses while start/stop input grounded
// - digital mode counts elapsed measurement time upward
// - digital mode pause holds duration of last measurement
// - steady run symbol, flashing while regulating, pause symbol paused
// - four operating modes selectable through the menu
// - up and down pressed together returns one menu level
// - select during edit moves cursor to next digit
// - edit committed only by select after last digit, else discarded
// - ISO ordinals one to six shown as less-or-equal-six
// - NAS and GOST show a single ordinal number
// - ISO largest channel shown small and not evaluated
//
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module mcs_sequencer
  import mcs_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
  // clock and reset
  input  wire logic           pclk,
  input  wire logic           presetn,
  // apb slave
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [7:0]     paddr,
  input  wire logic [31:0]    pwdata,
  output var  logic [31:0]    prdata,
  output var  logic           pready,
  output var  logic           pslverr,
  // operator and control inputs
  input  wire logic           btn_up,
  input  wire logic           btn_down,
  input  wire logic           btn_sel,
  input  wire logic           start_stop_in,
  input  wire logic           particles_enough,
  input  wire mcs_ord_in_t    ord_in,
  // display
  output var  mcs_sym_t       status_sym,
  output var  mcs_time_disp_t time_disp,
  output var  mcs_ord_disp_t  ord_disp
);

  ////////////////////////////////////////////////////////////////////////////
  // functions

  function automatic mcs_time_disp_t to_mmss(input logic [16:0] s, input logic dash);
    logic [16:0] m;
    logic [16:0] r;
    m = s / SEC_PER_MIN;
    r = s - m * SEC_PER_MIN;
    to_mmss.dashes  = dash;
    to_mmss.minutes = m[10:0];
    to_mmss.seconds = r[5:0];
  endfunction : to_mmss

  function automatic logic [2:0] item_digits(input mcs_item_t it);
    case (it)
      ITEM_MEAS:  item_digits = 3'h3;
      ITEM_PAUSE: item_digits = 3'h5;
      default:    item_digits = 3'h1;
    endcase
  endfunction : item_digits

  function automatic logic [16:0] pow10(input logic [2:0] e);
    case (e)
      3'h1:    pow10 = 17'h0000a;
      3'h2:    pow10 = 17'h00064;
      3'h3:    pow10 = 17'h003e8;
      3'h4:    pow10 = 17'h02710;
      default: pow10 = 17'h00001;
    endcase
  endfunction : pow10

  function automatic logic meas_ok(input logic [16:0] v);
    meas_ok = (v >= MEAS_MIN) && (v <= MEAS_MAX);
  endfunction : meas_ok

  function automatic logic pause_ok(input logic [16:0] v);
    pause_ok = (v >= PAUSE_MIN) && (v <= PAUSE_MAX);
  endfunction : pause_ok

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [TICK_CW-1:0] tick_cnt_reg;
  logic               tick;
  logic               half_tick;
  logic               blink_reg;
  logic               up_prev_reg;
  logic               down_prev_reg;
  logic               sel_prev_reg;
  logic               up_press;
  logic               down_press;
  logic               sel_press;
  logic               back_press;
  mcs_mode_t          mode_reg;
  mcs_std_t           std_reg;
  logic               run_reg;
  logic [16:0]        meas_reg;
  logic [16:0]        pause_reg;
  mcs_menu_t          menu_reg;
  mcs_item_t          item_reg;
  logic [2:0]         cursor_reg;
  logic [16:0]        edit_reg;
  logic [16:0]        weight;
  logic               commit;
  mcs_phase_t         phase_reg;
  logic [16:0]        elapsed_reg;
  logic [16:0]        reg_cnt_reg;
  logic [16:0]        target_reg;
  logic [16:0]        last_reg;
  logic               dash_reg;
  logic               apb_wr;
  logic               apb_rd;
  logic               addr_ok;
  logic               wr_bad;
  logic               pause_wr;
  logic [16:0]        pause_wr_val;
  logic               stop_req;
  logic [16:0]        elapsed_inc;

  ////////////////////////////////////////////////////////////////////////////
  // one-second tick and blink phase

  assign tick      = (tick_cnt_reg == TICK_CW'(TICK_CYCLES - 1));
  assign half_tick = (tick_cnt_reg == TICK_CW'(TICK_CYCLES / 2));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_reg <= '0;
    end else if (tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_reg <= 1'b0;
    end else if (tick || half_tick) begin
      blink_reg <= ~blink_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // buttons

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_prev_reg   <= 1'b0;
      down_prev_reg <= 1'b0;
      sel_prev_reg  <= 1'b0;
    end else begin
      up_prev_reg   <= btn_up;
      down_prev_reg <= btn_down;
      sel_prev_reg  <= btn_sel;
    end
  end

  // a press of one arrow while the other is held counts as back only
  assign back_press = btn_up && btn_down && (!up_prev_reg || !down_prev_reg);
  assign up_press   = btn_up && !up_prev_reg && !btn_down;
  assign down_press = btn_down && !down_prev_reg && !btn_up;
  assign sel_press  = btn_sel && !sel_prev_reg;

  ////////////////////////////////////////////////////////////////////////////
  // menu and value editing

  assign weight = pow10(3'(item_digits(item_reg) - cursor_reg - 3'h1));
  assign commit = (menu_reg == MENU_EDIT) && sel_press && !back_press
                  && (cursor_reg == item_digits(item_reg) - 3'h1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      menu_reg   <= MENU_TOP;
      item_reg   <= ITEM_MODE;
      cursor_reg <= '0;
      edit_reg   <= '0;
    end else begin
      case (menu_reg)
        MENU_TOP: begin
          if (up_press || down_press) begin
            menu_reg <= MENU_LIST;
          end else if (sel_press && mode_reg != MODE_BUTTON) begin
            menu_reg <= MENU_LIST;
          end
        end
        MENU_LIST: begin
          if (back_press) begin
            menu_reg <= MENU_TOP;
          end else if (up_press) begin
            item_reg <= mcs_item_t'(item_reg + 2'h1);
          end else if (down_press) begin
            item_reg <= mcs_item_t'(item_reg - 2'h1);
          end else if (sel_press) begin
            menu_reg   <= MENU_EDIT;
            cursor_reg <= '0;
            case (item_reg)
              ITEM_MODE:  edit_reg <= {15'h0000, mode_reg};
              ITEM_MEAS:  edit_reg <= meas_reg;
              ITEM_PAUSE: edit_reg <= pause_reg;
              default:    edit_reg <= {15'h0000, std_reg};
            endcase
          end
        end
        MENU_EDIT: begin
          if (back_press) begin
            menu_reg <= MENU_LIST;
          end else if (commit) begin
            menu_reg <= MENU_LIST;
          end else if (sel_press) begin
            cursor_reg <= cursor_reg + 3'h1;
          end else if (up_press && edit_reg <= EDIT_MAX - weight) begin
            edit_reg <= edit_reg + weight;
          end else if (down_press && edit_reg >= weight) begin
            edit_reg <= edit_reg - weight;
          end
        end
        default: menu_reg <= MENU_TOP;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave and settings

  assign apb_wr  = psel && penable && pready && pwrite;
  assign apb_rd  = psel && !penable && !pwrite;
  assign addr_ok = (paddr == ADDR_CTRL) || (paddr == ADDR_MEAS) || (paddr == ADDR_PAUSE)
                   || (paddr == ADDR_STATUS) || (paddr == ADDR_TIME) || (paddr == ADDR_LAST);
  assign wr_bad  = pwrite && ((paddr == ADDR_MEAS && !meas_ok(pwdata[16:0]))
                   || (paddr == ADDR_PAUSE && !pause_ok(pwdata[16:0]))
                   || paddr == ADDR_STATUS || paddr == ADDR_TIME || paddr == ADDR_LAST);

  always_comb begin
    pause_wr     = 1'b0;
    pause_wr_val = pwdata[16:0];
    if (apb_wr && paddr == ADDR_PAUSE && pause_ok(pwdata[16:0])) begin
      pause_wr = 1'b1;
    end else if (commit && item_reg == ITEM_PAUSE && pause_ok(edit_reg)) begin
      pause_wr     = 1'b1;
      pause_wr_val = edit_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && (!addr_ok || wr_bad);
      prdata  <= '0;
      if (apb_rd) begin
        case (paddr)
          ADDR_CTRL: begin
            prdata[CTRL_MODE_LSB +: 2] <= mode_reg;
            prdata[CTRL_STD_LSB +: 2]  <= std_reg;
            prdata[CTRL_RUN_BIT]       <= run_reg;
          end
          ADDR_MEAS:  prdata[16:0] <= meas_reg;
          ADDR_PAUSE: prdata[16:0] <= pause_reg;
          ADDR_STATUS: begin
            prdata[ST_PHASE_LSB +: 2] <= phase_reg;
            prdata[ST_DASH_BIT]       <= dash_reg;
            prdata[ST_MENU_LSB +: 2]  <= menu_reg;
            prdata[ST_CUR_LSB +: 3]   <= cursor_reg;
          end
          ADDR_TIME: prdata[16:0] <= elapsed_reg;
          ADDR_LAST: prdata[16:0] <= last_reg;
          default:   prdata       <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg  <= mcs_mode_t'(MODE_RST);
      std_reg   <= mcs_std_t'(STD_RST);
      run_reg   <= 1'b0;
      meas_reg  <= MEAS_DEF;
      pause_reg <= PAUSE_DEF;
    end else begin
      if (pause_wr) begin
        pause_reg <= pause_wr_val;
      end
      if (apb_wr && paddr == ADDR_CTRL) begin
        mode_reg <= mcs_mode_t'(pwdata[CTRL_MODE_LSB +: 2]);
        std_reg  <= mcs_std_t'(pwdata[CTRL_STD_LSB +: 2]);
        run_reg  <= pwdata[CTRL_RUN_BIT];
      end else if (apb_wr && paddr == ADDR_MEAS && meas_ok(pwdata[16:0])) begin
        meas_reg <= pwdata[16:0];
      end else if (commit) begin
        case (item_reg)
          ITEM_MODE: if (edit_reg < ENUM_LIMIT) mode_reg <= mcs_mode_t'(edit_reg[1:0]);
          ITEM_MEAS: if (meas_ok(edit_reg)) meas_reg <= edit_reg;
          ITEM_STD:  if (edit_reg < ENUM_LIMIT) std_reg <= mcs_std_t'(edit_reg[1:0]);
          default:   ;
        endcase
      end else if (menu_reg == MENU_TOP && sel_press && mode_reg == MODE_BUTTON) begin
        run_reg <= ~run_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // measurement sequencer

  assign elapsed_inc = elapsed_reg + 17'h00001;

  always_comb begin
    case (mode_reg)
      MODE_DIGIO:  stop_req = !start_stop_in;
      MODE_BUTTON: stop_req = !run_reg;
      default:     stop_req = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg   <= PH_REGULATE;
      elapsed_reg <= '0;
      reg_cnt_reg <= '0;
      target_reg  <= PAUSE_DEF;
      last_reg    <= '0;
      dash_reg    <= 1'b0;
    end else begin
      case (phase_reg)
        PH_IDLE: begin
          if (!stop_req) begin
            phase_reg   <= PH_REGULATE;
            reg_cnt_reg <= '0;
          end
        end
        PH_REGULATE: begin
          if (stop_req) begin
            phase_reg   <= (mode_reg == MODE_DIGIO) ? PH_PAUSE : PH_IDLE;
          end else if (tick && reg_cnt_reg + 17'h00001 >= REG_TIME_S) begin
            phase_reg   <= PH_MEASURE;
            elapsed_reg <= '0;
          end else if (tick) begin
            reg_cnt_reg <= reg_cnt_reg + 17'h00001;
          end
        end
        PH_MEASURE: begin
          if (stop_req) begin
            phase_reg   <= PH_PAUSE;
            last_reg    <= elapsed_reg;
            elapsed_reg <= '0;
          end else if (tick) begin
            elapsed_reg <= elapsed_inc;
            if (mode_reg == MODE_TIME && elapsed_inc >= meas_reg) begin
              phase_reg   <= PH_PAUSE;
              last_reg    <= elapsed_inc;
              elapsed_reg <= '0;
              target_reg  <= pause_reg;
              dash_reg    <= 1'b0;
            end else if (mode_reg == MODE_AUTO && (elapsed_inc >= AUTO_MAX_S
                         || (particles_enough && elapsed_inc >= AUTO_MIN_S))) begin
              phase_reg   <= PH_REGULATE;
              reg_cnt_reg <= '0;
              last_reg    <= elapsed_inc;
            end
          end
        end
        PH_PAUSE: begin
          if (mode_reg != MODE_TIME) begin
            if (!stop_req) begin
              phase_reg   <= PH_REGULATE;
              reg_cnt_reg <= '0;
            end
          end else begin
            if (pause_wr && pause_wr_val > elapsed_reg) begin
              target_reg <= pause_wr_val;
              dash_reg   <= 1'b0;
            end else if (pause_wr) begin
              dash_reg   <= 1'b1;
            end
            if (tick) begin
              elapsed_reg <= elapsed_inc;
              if (elapsed_inc >= target_reg) begin
                phase_reg   <= PH_REGULATE;
                reg_cnt_reg <= '0;
                dash_reg    <= 1'b0;
              end
            end
          end
        end
        default: phase_reg <= PH_REGULATE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // display outputs

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_sym <= SYM_RUN_FLASH;
      time_disp  <= '0;
    end else begin
      case (phase_reg)
        PH_REGULATE: status_sym <= blink_reg ? SYM_RUN_FLASH : SYM_PAUSE;
        PH_MEASURE:  status_sym <= SYM_RUN;
        default:     status_sym <= SYM_PAUSE;
      endcase
      if (mode_reg == MODE_TIME) begin
        case (phase_reg)
          PH_MEASURE: time_disp <= to_mmss(meas_reg - elapsed_reg, 1'b0);
          PH_PAUSE:   time_disp <= to_mmss(target_reg - elapsed_reg, dash_reg);
          default:    time_disp <= to_mmss(meas_reg, 1'b0);
        endcase
      end else begin
        case (phase_reg)
          PH_MEASURE: time_disp <= to_mmss(elapsed_reg, 1'b0);
          PH_PAUSE:   time_disp <= to_mmss(last_reg, 1'b0);
          default:    time_disp <= to_mmss(17'h00000, 1'b0);
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ord_disp <= '0;
    end else begin
      ord_disp       <= '0;
      ord_disp.num_a <= ord_in.ch4;
      ord_disp.num_b <= ord_in.ch6;
      ord_disp.num_c <= ord_in.ch14;
      ord_disp.num_d <= ord_in.ch21;
      case (std_reg)
        STD_ISO: begin
          ord_disp.count   <= 3'h3;
          ord_disp.small_d <= 1'b1;
          ord_disp.le6[0]  <= ord_in.ch4 >= ISO_LE6_LO && ord_in.ch4 <= ISO_LE6_HI;
          ord_disp.le6[1]  <= ord_in.ch6 >= ISO_LE6_LO && ord_in.ch6 <= ISO_LE6_HI;
          ord_disp.le6[2]  <= ord_in.ch14 >= ISO_LE6_LO && ord_in.ch14 <= ISO_LE6_HI;
        end
        STD_SAE: ord_disp.count <= 3'h4;
        default: begin
          ord_disp.count <= 3'h1;
          ord_disp.num_a <= ord_in.single;
          ord_disp.num_b <= '0;
          ord_disp.num_c <= '0;
          ord_disp.num_d <= '0;
        end
      endcase
    end
  end

endmodule : mcs_sequencer
`default_nettype wire

// ---- mcs_sequencer_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
module mcs_sequencer_assertions
  import mcs_pkg::*;
(
  // clock, reset and apb
  input wire logic           pclk,
  input wire logic           presetn,
  input wire logic           psel,
  input wire logic           penable,
  input wire logic           pwrite,
  input wire logic [7:0]     paddr,
  input wire logic [31:0]    pwdata,
  input wire logic           pready,
  input wire logic           pslverr,
  // display side
  input wire mcs_ord_in_t    ord_in,
  input wire mcs_time_disp_t time_disp,
  input wire mcs_ord_disp_t  ord_disp
);
  wire setw = psel && !penable && pwrite;
  wire mok  = pwdata[16:0] inside {[MEAS_MIN:MEAS_MAX]};
  wire pok  = pwdata[16:0] inside {[PAUSE_MIN:PAUSE_MAX]};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////
  AST_PREADY: assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  AST_ERR_RDY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_MEAS: assert property (setw && paddr == ADDR_MEAS |=> pslverr == !mok)
    else $error("measuring time range check wrong");
  AST_PAUSE: assert property (setw && paddr == ADDR_PAUSE |=> pslverr == !pok)
    else $error("pause time range check wrong");
  AST_SEC: assert property (!time_disp.dashes |-> time_disp.seconds < 6'h3c)
    else $error("seconds field out of range");
  AST_TICK: assert property ($changed(time_disp) && !$past(psel) && !$past(psel, 2)
    && !$past(psel, 3) |=> $stable(time_disp))
    else $error("time display moved twice within a tick");
  AST_LE6: assert property (ord_disp.count == 3'h3 |-> ord_disp.le6 ==
    {$past(ord_in.ch14) inside {[ISO_LE6_LO:ISO_LE6_HI]},
     $past(ord_in.ch6) inside {[ISO_LE6_LO:ISO_LE6_HI]},
     $past(ord_in.ch4) inside {[ISO_LE6_LO:ISO_LE6_HI]}})
    else $error("le6 marks wrong");
  AST_SGL: assert property (ord_disp.count == 3'h1 |-> ord_disp.num_a == $past(ord_in.single))
    else $error("single ordinal wrong");
  AST_SMALL: assert property (ord_disp.count == 3'h3 |-> ord_disp.small_d
    && ord_disp.num_d == $past(ord_in.ch21))
    else $error("largest channel not shown small");
endmodule : mcs_sequencer_assertions

bind mcs_sequencer mcs_sequencer_assertions u_ast (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .ord_in(ord_in), .time_disp(time_disp),
  .ord_disp(ord_disp));
`default_nettype wire

// ---- mcs_operator_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module mcs_operator_model (
  // clock and bench command
  input  wire logic pclk,
  input  wire logic ground_req,
  // lines into the sequencer
  output var  logic btn_up,
  output var  logic btn_down,
  output var  logic btn_sel,
  output var  logic start_stop_in
);
  initial begin
    btn_up        = 1'b0;
    btn_down      = 1'b0;
    btn_sel       = 1'b0;
    start_stop_in = 1'b1;
  end
  // grounded pin reads low, open or supplied pin reads high
  always @(posedge pclk) start_stop_in <= !ground_req;
  // presses given as {up, down, sel}; both arrows together go back a level
  task automatic press(input logic [2:0] b);
    @(posedge pclk);
    {btn_up, btn_down, btn_sel} <= b;
    repeat (3) @(posedge pclk);
    {btn_up, btn_down, btn_sel} <= 3'b000;
    repeat (3) @(posedge pclk);
  endtask : press
endmodule : mcs_operator_model
`default_nettype wire

// ---- mcs_sequencer_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module mcs_sequencer_tb_top
  import mcs_pkg::*;
;
  logic           pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic           btn_up, btn_down, btn_sel, start_stop_in, pen, gnd;
  logic [7:0]     paddr;
  logic [31:0]    pwdata, prdata, rd;
  mcs_ord_in_t    ord_in;
  mcs_sym_t       status_sym;
  mcs_time_disp_t time_disp;
  mcs_ord_disp_t  ord_disp;
  int             err_count, n_compared;
  logic [7:0]     ta [10] = '{ADDR_MEAS, ADDR_MEAS, ADDR_MEAS, ADDR_MEAS, ADDR_PAUSE,
                              ADDR_PAUSE, ADDR_PAUSE, ADDR_PAUSE, 8'h18, ADDR_STATUS};
  logic [31:0]    tv [10] = '{32'h1d, 32'h1e, 32'h12c, 32'h12d, 32'h0, 32'h1,
                              32'h15180, 32'h15181, 32'h0, 32'h0};
  logic [0:9]     te = 10'b1001100111;
  logic [2:0]     cnt [4] = '{3'h3, 3'h4, 3'h1, 3'h1};

  mcs_sequencer #(.TICK_CYCLES(10)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .btn_up(btn_up), .btn_down(btn_down),
    .btn_sel(btn_sel), .start_stop_in(start_stop_in), .particles_enough(pen),
    .ord_in(ord_in), .status_sym(status_sym), .time_disp(time_disp), .ord_disp(ord_disp));
  mcs_operator_model u_op (.pclk(pclk), .ground_req(gnd), .btn_up(btn_up),
    .btn_down(btn_down), .btn_sel(btn_sel), .start_stop_in(start_stop_in));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (err_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out
  task automatic tmo();
    err_count++;
    close_out();
  endtask : tmo
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  function automatic logic [31:0] fmt(input logic [16:0] v);
    return {14'h0, 1'b0, 11'(v / SEC_PER_MIN), 6'(v % SEC_PER_MIN)};
  endfunction : fmt
  function automatic logic in_le6(input logic [4:0] v);
    return v >= ISO_LE6_LO && v <= ISO_LE6_HI;
  endfunction : in_le6
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (int n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
      if (n == 19) tmo();
    end
    rd      = prdata;
    er      = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdc
  task automatic wph(input logic [1:0] p);
    for (int n = 0; n < 2000; n++) begin
      apb(1'b0, ADDR_STATUS, 32'h0);
      if (rd[1:0] === p) return;
    end
    tmo();
  endtask : wph
  // waits for the next second, then compares the display to the phase time
  task automatic dchk(input logic up, input logic [16:0] t);
    mcs_time_disp_t h;
    h = time_disp;
    for (int n = 0; n < 40 && time_disp === h; n++) @(posedge pclk);
    if (time_disp === h) tmo();
    apb(1'b0, ADDR_TIME, 32'h0);
    chk(32'(time_disp), fmt(up ? rd[16:0] : 17'(t - rd[16:0])));
  endtask : dchk

  initial begin
    int             s;
    logic [16:0]    m;
    mcs_ord_in_t    o;
    mcs_time_disp_t held;
    {presetn, psel, penable, pwrite, paddr, pwdata, pen, gnd} = '0;
    ord_in     = '0;
    err_count  = 0;
    n_compared = 0;
    s = $urandom(14);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rdc(ADDR_STATUS, 32'h1);
    rdc(ADDR_MEAS, 32'h3c);
    rdc(ADDR_PAUSE, 32'ha);
    for (int i = 0; i < 10; i++) begin
      apb(1'b1, ta[i], tv[i]);
      chk(32'(er), 32'(te[i]));
    end
    rdc(ADDR_MEAS, 32'h12c);
    rdc(ADDR_PAUSE, 32'h15180);
    repeat (3) begin
      m = 17'(MEAS_MIN + $urandom % 271);
      apb(1'b1, ADDR_MEAS, 32'(m));
      rdc(ADDR_MEAS, 32'(m));
    end
    apb(1'b1, ADDR_MEAS, 32'h5a);
    apb(1'b1, ADDR_PAUSE, 32'h5);
    wph(PH_REGULATE);
    chk(32'(status_sym != SYM_RUN), 32'h1);
    wph(PH_MEASURE);
    chk(32'(status_sym), 32'(SYM_RUN));
    dchk(1'b0, 17'h5a);
    wph(PH_PAUSE);
    chk(32'(status_sym), 32'(SYM_PAUSE));
    dchk(1'b0, 17'h5);
    apb(1'b1, ADDR_PAUSE, 32'h1);
    repeat (3) @(posedge pclk);
    chk(32'(time_disp.dashes), 32'h1);
    wph(PH_REGULATE);
    chk(32'(time_disp.dashes), 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h1);
    rdc(ADDR_CTRL, 32'h1);
    wph(PH_MEASURE);
    dchk(1'b1, 17'h0);
    @(posedge pclk);
    gnd <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(32'(rd[1:0]), 32'(PH_PAUSE));
    held = time_disp;
    repeat (30) @(posedge pclk);
    chk(32'(time_disp), 32'(held));
    u_op.press(3'b100);
    u_op.press(3'b100);
    u_op.press(3'b001);
    rdc(ADDR_STATUS, 32'h23);
    u_op.press(3'b100);
    u_op.press(3'b001);
    rdc(ADDR_STATUS, 32'h123);
    u_op.press(3'b001);
    u_op.press(3'b001);
    rdc(ADDR_MEAS, 32'hbe);
    u_op.press(3'b001);
    u_op.press(3'b100);
    u_op.press(3'b110);
    rdc(ADDR_MEAS, 32'hbe);
    rdc(ADDR_STATUS, 32'h13);
    gnd <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      o = 25'($urandom);
      if (k == 0) o.ch4 = 5'h06;
      if (k == 0) o.ch6 = 5'h07;
      @(posedge pclk);
      ord_in <= o;
      pen    <= 1'($urandom);
      apb(1'b1, ADDR_CTRL, 32'(k * 5));
      rdc(ADDR_CTRL, 32'(k * 5));
      chk(32'(ord_disp.count), 32'(cnt[k]));
      if (k == 0) chk(32'(ord_disp.le6), {29'h0, in_le6(o.ch14), in_le6(o.ch6), in_le6(o.ch4)});
      if (k == 0) chk(32'(ord_disp.num_d), 32'(o.ch21));
      if (k > 1) chk(32'(ord_disp.num_a), 32'(o.single));
    end
    pen <= 1'b1;
    wph(PH_MEASURE);
    wph(PH_REGULATE);
    rdc(ADDR_LAST, 32'h2d);
    close_out();
  end
endmodule : mcs_sequencer_tb_top
`default_nettype wire
